// *** src/ecf_timer.v ***
// 8-bit timer/event counter with pulse-width capture and frequency divider
// assumes one AHB-Lite master on hclk; ext pins and crystal input are async
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "ecf_defs.vh"

module ecf_timer
#(
    parameter DUAL_OUTPUT = 1          // 1: pair device gated by port bit 0, else bit 1
)
(
    // ahb-lite slave
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // external pins and clocks
    input  wire        ext_count_pin,
    input  wire        low_freq_crystal,
    input  wire        sleep_mode,
    input  wire        alt_overflow,
    // divider pins
    output reg         freq_div_out,
    output reg         freq_div_out_oe,
    output reg         freq_div_out_n,
    output reg         freq_div_out_n_oe,
    // events
    output reg         overflow_irq,
    output reg         wake_req
);

    // register map, one byte in the low lane of each aligned word:
    //   0x0 control: [7:6] mode, [5] clock source, [4] run, [3] edge select,
    //                [2:0] prescale code
    //   0x4 preload: reload value; a write while stopped also loads the count
    //   0x8 count:   live count, read only; writes to it are dropped
    //   0xC misc:    [0] divider source, [2:1] pin enable, [4] gate bit,
    //                [5] single-output gate bit, [7:6] pin directions, 1 = input
    // only haddr[3:2] is decoded, so every higher address aliases onto these four;
    // hsize is ignored, since each register is reached by a whole-word access
    // after reset: control 0x08, preload 0x00, count 0x00, misc 0xC0, which leaves
    // both divider pins as inputs until software turns them round

    // mode codes: 01 event counting, 10 plain timer, 11 pulse capture;
    // 00 leaves the counter idle whatever the run bit says

    // bus timing: a write needs no wait state and lands at the end of its data
    // phase; a read takes one wait state, so hrdata comes from a flop and a read
    // right behind a write already returns the new value

    // pin timing: an edge on ext_count_pin reaches the counter three clocks later,
    // two synchroniser stages and the edge flop; levels shorter than about two
    // clocks may be lost, and a measured width carries one tick of jitter

    // divider: each selected overflow flips div_q and the pins follow one clock
    // later; a clear gate bit holds both pins low whatever div_q is, and without
    // DUAL_OUTPUT the complement pin never drives

    // capture state machine, one-hot
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_ARMED = 3'h2;
    localparam [2:0] ST_COUNT = 3'h4;

    // software registers and core state
    reg  [7:0]  timer_control_reg;
    reg  [7:0]  preload;
    reg  [7:0]  counter;
    reg  [7:0]  misc_control_a;
    reg  [2:0]  cap_state;
    reg  [2:0]  next_cap_state;
    reg         div_q;

    // bus pipeline
    reg         wr_pend;
    reg  [3:0]  wr_addr;
    reg         rd_pend;
    reg  [3:0]  rd_addr;

    // synchronisers and clock enables
    reg         pin_s1;
    reg         pin_s2;
    reg         pin_s3;
    reg         lfx_s1;
    reg         lfx_s2;
    reg         lfx_s3;
    reg  [1:0]  sys_div;
    reg  [6:0]  psc_cnt;

    // control fields and mode decode; plain timer mode shares the reload path
    wire [1:0]  mode       = timer_control_reg[`ECF_MODE_HI:`ECF_MODE_LO];
    wire        run        = timer_control_reg[`ECF_RUN];
    wire        edge_sel   = timer_control_reg[`ECF_EDGE];
    wire [2:0]  psc_sel    = timer_control_reg[`ECF_PSC_HI:`ECF_PSC_LO];
    wire        mode_event = (mode == `ECF_MODE_EVENT);
    wire        mode_cap   = (mode == `ECF_MODE_CAPTURE);
    wire        mode_tmr   = (mode == `ECF_MODE_TIMER);

    // edges come from two registered samples after the synchroniser
    wire        pin_rise   = pin_s2 & ~pin_s3;
    wire        pin_fall   = ~pin_s2 & pin_s3;
    wire        lfx_rise   = lfx_s2 & ~lfx_s3;

    // event mode edge; capture start is the other edge, stop is the selected one
    wire        sel_edge   = edge_sel ? pin_fall : pin_rise;
    wire        cap_start  = edge_sel ? pin_rise : pin_fall;
    wire        cap_stop   = edge_sel ? pin_fall : pin_rise;

    // internal clock source: fsys/4 when set to zero, crystal when set to one
    wire        src_en     = timer_control_reg[`ECF_CLK_SRC] ? lfx_rise
                                                            : (sys_div == `ECF_SYS4_LAST);
    // tick when the low psc_sel bits of the prescaler are all ones
    wire [6:0]  psc_mask   = (7'h7F >> (3'd7 - psc_sel));
    wire        int_tick   = src_en & ((psc_cnt & psc_mask) == psc_mask);

    // one counting step this cycle
    wire        inc = run & ((mode_event & sel_edge)
                           | (mode_tmr & int_tick)
                           | (mode_cap & (cap_state == ST_COUNT) & int_tick));
    wire        ovf = inc & (counter == `ECF_FULL);

    // bus decode: transfer accept in the address phase, register writes in the data phase
    wire        ahb_go  = hsel & hready & htrans[1];
    wire        wr_ctrl = wr_pend & (wr_addr == `ECF_OFS_CTRL);
    wire        wr_pre  = wr_pend & (wr_addr == `ECF_OFS_PRELOAD);
    wire        wr_misc = wr_pend & (wr_addr == `ECF_OFS_MISC);
    // capture ends on the stop edge while counting; it drops run below
    wire        cap_done = mode_cap & run & (cap_state == ST_COUNT) & cap_stop;

    // divider source and gating
    // a single-output part gates on the second port data bit instead
    wire        div_clk_ev = misc_control_a[`ECF_DIV_SRC] ? alt_overflow : ovf;
    wire        gate_bit   = (DUAL_OUTPUT != 0) ? misc_control_a[`ECF_PA_BIT0]
                                                : misc_control_a[`ECF_PA_BIT1];
    wire [1:0]  pin_en     = misc_control_a[`ECF_PIN_EN_HI:`ECF_PIN_EN_LO];

    // pin and crystal synchronisers; stage one feeds stage two only
    // reset low matches the idle level of the pulse source; a pin that rests high
    // gives one false rising edge after reset, harmless since run resets to zero
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
            lfx_s1 <= 1'b0;
            lfx_s2 <= 1'b0;
            lfx_s3 <= 1'b0;
        end
        else
        begin
            pin_s1 <= ext_count_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            lfx_s1 <= low_freq_crystal;
            lfx_s2 <= lfx_s1;
            lfx_s3 <= lfx_s2;
        end
    end

    // free-running fsys/4 divider and prescaler; a shared prescaler keeps it simple,
    // at the cost that the first period after a rate change can be short
    // the crystal source passes through the same prescaler as fsys/4
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sys_div <= 2'h0;
            psc_cnt <= 7'h00;
        end
        else
        begin
            sys_div <= sys_div + 2'h1;
            if (src_en)
                psc_cnt <= psc_cnt + 7'h01;
        end
    end

    // capture sequencing: armed waits for the start edge, count until the stop edge
    // arming takes one clock, so a start edge in the very cycle run is set is missed;
    // leaving capture mode or clearing run drops straight back to idle
    always @*
    begin
        next_cap_state = cap_state;
        case (cap_state)
            ST_IDLE:
                if (mode_cap & run)
                    next_cap_state = ST_ARMED;
            ST_ARMED:
                if (!(mode_cap & run))
                    next_cap_state = ST_IDLE;
                else if (cap_start)
                    next_cap_state = ST_COUNT;
            ST_COUNT:
                if (!(mode_cap & run) || cap_stop)
                    next_cap_state = ST_IDLE;
            default:
                next_cap_state = ST_IDLE;
        endcase
    end

    // capture state register
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cap_state <= ST_IDLE;
        else
            cap_state <= next_cap_state;
    end

    // bus pipeline: writes land in the data phase, reads take one wait state
    // the address is captured only for an accepted transfer, so idle cycles keep it
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend   <= 1'b0;
            wr_addr   <= 4'h0;
            rd_pend   <= 1'b0;
            rd_addr   <= 4'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end
        else
        begin
            wr_pend <= ahb_go & hwrite;
            rd_pend <= ahb_go & ~hwrite;
            if (ahb_go)
            begin
                wr_addr <= {haddr[3:2], 2'h0};
                rd_addr <= {haddr[3:2], 2'h0};
            end
            // wait state lets hrdata come from a flop and see a write just before
            hreadyout <= ~(ahb_go & ~hwrite);
            if (rd_pend)
            begin
                case (rd_addr)
                    `ECF_OFS_CTRL:    hrdata <= {24'h000000, timer_control_reg};
                    `ECF_OFS_PRELOAD: hrdata <= {24'h000000, preload};
                    `ECF_OFS_COUNT:   hrdata <= {24'h000000, counter};
                    `ECF_OFS_MISC:    hrdata <= {24'h000000, misc_control_a};
                    default:          hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control register; only capture completion clears run by hardware
    // a software write in the cycle a capture ends is dropped whole, so the clear
    // can never be undone by a stale write of the run bit
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            timer_control_reg <= `ECF_CTRL_RST;
        else if (cap_done)
            timer_control_reg[`ECF_RUN] <= 1'b0;
        else if (wr_ctrl)
            timer_control_reg <= hwdata[7:0];
    end

    // preload and misc registers
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            preload        <= `ECF_PRELOAD_RST;
            misc_control_a <= `ECF_MISC_RST;
        end
        else
        begin
            if (wr_pre)
                preload <= hwdata[7:0];
            if (wr_misc)
                misc_control_a <= hwdata[7:0];
        end
    end

    // counter: reload on overflow, direct load from a preload write while off
    // a preload written while running waits for the next overflow reload, so the
    // period in progress is never cut short
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            counter <= 8'h00;
        else if (wr_pre && !run)
            counter <= hwdata[7:0];
        else if (ovf)
            counter <= preload;
        else if (inc)
            counter <= counter + 8'h01;
    end

    // overflow request, wake request and divider toggle
    // the request and wake pulses last one clock each; sleep_mode comes from logic
    // on hclk, so it needs no synchroniser
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            overflow_irq <= 1'b0;
            wake_req     <= 1'b0;
            div_q        <= 1'b0;
        end
        else
        begin
            overflow_irq <= ovf;
            wake_req     <= ovf & sleep_mode;
            if (div_clk_ev)
                div_q <= ~div_q;
        end
    end

    // divider pins: pin_en 01 true only, 1x pair; direction bit 0 means output,
    // since a set direction bit makes the shared pin an input
    // the pins are registered once more so every output comes straight from a flop
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            freq_div_out      <= 1'b0;
            freq_div_out_oe   <= 1'b0;
            freq_div_out_n    <= 1'b0;
            freq_div_out_n_oe <= 1'b0;
        end
        else
        begin
            freq_div_out      <= gate_bit & div_q;
            freq_div_out_n    <= gate_bit & ~div_q;
            freq_div_out_oe   <= (pin_en != 2'h0)
                                 & ~misc_control_a[`ECF_PA_DIR0];
            freq_div_out_n_oe <= pin_en[1] & (DUAL_OUTPUT != 0)
                                 & ~misc_control_a[`ECF_PA_DIR1];
        end
    end

endmodule // ecf_timer
`default_nettype wire

// *** src/ecf_defs.vh ***
// register offsets, field positions and reset values of the event capture timer
// included by the timer module; holds definitions only
`ifndef ECF_DEFS_VH
`define ECF_DEFS_VH

// byte offsets on the bus (one aligned word each)
`define ECF_OFS_CTRL      4'h0
`define ECF_OFS_PRELOAD   4'h4
`define ECF_OFS_COUNT     4'h8
`define ECF_OFS_MISC      4'hC

// timer_control_reg fields
`define ECF_MODE_HI       7
`define ECF_MODE_LO       6
`define ECF_CLK_SRC       5
`define ECF_RUN           4
`define ECF_EDGE          3
`define ECF_PSC_HI        2
`define ECF_PSC_LO        0

// operating mode codes
`define ECF_MODE_EVENT    2'h1
`define ECF_MODE_TIMER    2'h2
`define ECF_MODE_CAPTURE  2'h3

// misc_control_a fields
`define ECF_DIV_SRC       0
`define ECF_PIN_EN_HI     2
`define ECF_PIN_EN_LO     1
`define ECF_PA_BIT0       4
`define ECF_PA_BIT1       5
`define ECF_PA_DIR0       6
`define ECF_PA_DIR1       7

// reset values
`define ECF_CTRL_RST      8'h08
`define ECF_PRELOAD_RST   8'h00
`define ECF_MISC_RST      8'hC0

// full count and system clock divide for the fsys/4 source
`define ECF_FULL          8'hFF
`define ECF_SYS4_LAST     2'h3

`endif

// *** tb/ecf_timer_chk.sv ***
// port checker for the event capture timer
// bound into ecf_timer; one clock, async active-low reset
`timescale 1ns/10ps
`default_nettype none
module ecf_timer_chk
(
    // bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // pins and events
    input wire logic        sleep_mode,
    input wire logic        alt_overflow,
    input wire logic        freq_div_out,
    input wire logic        freq_div_out_n,
    input wire logic        overflow_irq,
    input wire logic        wake_req
);
    logic       take;
    logic [2:0] wq;
    logic [2:0] evq;
    assign take = hsel && hready && htrans[1];
    // cycles since the last write or divider event; saturates so it never wraps
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            wq  <= 3'h0;
            evq <= 3'h0;
        end
        else
        begin
            wq  <= (take && hwrite) ? 3'h0 : wq + {2'h0, wq != 3'h7};
            evq <= (take && hwrite) || overflow_irq || alt_overflow ? 3'h0
                 : evq + {2'h0, evq != 3'h7};
        end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay:    assert property (hresp == 1'b0) else $error("error response");
    a_read_wait:    assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
    a_rdata_upper:  assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_irq_single:   assert property (overflow_irq |=> !overflow_irq)
        else $error("overflow pulse too long");
    a_wake_cause:   assert property (wake_req |-> overflow_irq && $past(sleep_mode))
        else $error("wake without overflow in sleep");
    a_wake_sleep:   assert property (overflow_irq && $past(sleep_mode) |-> wake_req)
        else $error("overflow in sleep did not wake");
    a_div_inverse:  assert property (!(freq_div_out && freq_div_out_n))
        else $error("divider pair both high");
    a_div_toggle:   assert property ($changed(freq_div_out) |-> (evq < 3'h5) or (##[0:2] overflow_irq))
        else $error("divider moved without overflow");
    a_gate_steady:  assert property (wq >= 3'h5 |-> $stable(freq_div_out | freq_div_out_n))
        else $error("divider enable moved without write");
    c_overflow: cover property (overflow_irq);
    c_wake:     cover property (wake_req);
    c_div_rise: cover property ($rose(freq_div_out));
endmodule // ecf_timer_chk
bind ecf_timer ecf_timer_chk u_ecf_timer_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
    .hrdata, .hreadyout, .hresp, .sleep_mode, .alt_overflow, .freq_div_out, .freq_div_out_n,
    .overflow_irq, .wake_req);
`default_nettype wire

// *** tb/ecf_pulse_src.sv ***
// external pulse source on the count pin
// stepped by the bench just after a rising hclk edge
`timescale 1ns/10ps
`default_nettype none
module ecf_pulse_src
(
    // clock
    input  wire logic hclk,
    // pin
    output var logic  ext_count_pin
);
    // pin rests low until the bench moves it
    initial ext_count_pin = 1'b0;
    // hold each level for whole cycles, far wider than the pin synchroniser
    task automatic set_level(input logic lvl, input int hold);
        ext_count_pin <= lvl;
        repeat (hold) @(posedge hclk);
    endtask
endmodule // ecf_pulse_src
`default_nettype wire

// *** tb/ecf_timer_tb_top.sv ***
// self-checking bench for the event capture timer
// assumes ecf_timer, its checker and ecf_pulse_src are compiled first
`timescale 1ns/10ps
`default_nettype none
module ecf_timer_tb_top;
    logic        hclk, hresetn, hsel, hwrite, sleep_mode, alt_overflow, b, lfx;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    wire         hreadyout, hresp, ext_count_pin, overflow_irq, wake_req;
    wire         freq_div_out, freq_div_out_oe, freq_div_out_n, freq_div_out_n_oe;
    int          errors = 0, tests_run = 0, cycles = 0, irqs = 0, wakes = 0;
    logic [7:0]  misc_tab [6] = '{8'h14, 8'h12, 8'h10, 8'h54, 8'hD4, 8'h24};
    logic [3:0]  out_tab [6] = '{4'hF, 4'hA, 4'h0, 4'h5, 4'h0, 4'hF};

    ecf_timer u_ecf_timer (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_count_pin,
        .low_freq_crystal(lfx), .sleep_mode, .alt_overflow, .freq_div_out, .freq_div_out_oe,
        .freq_div_out_n, .freq_div_out_n_oe, .overflow_irq, .wake_req);
    ecf_pulse_src u_ecf_pulse_src (.hclk, .ext_count_pin);

    // 125 MHz clock
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // slow crystal stand-in, 32 ns period, edges away from the rising hclk edge
    initial
    begin
        lfx = 1'b0;
        forever #16 lfx = ~lfx;
    end
    // event counts and the hang limit
    always @(posedge hclk)
    begin
        cycles++;
        irqs += (overflow_irq === 1'b1);
        wakes += (wake_req === 1'b1);
        if (cycles == 20000)
        begin
            errors++;
            summarize();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // one single ahb-lite transfer; called just after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), q, exp);
    endtask
    task automatic pn(input logic lvl, input int hold);
        u_ecf_pulse_src.set_level(lvl, hold);
    endtask
    // one pulse-width capture; the pin sits at the counting level when armed; s picks crystal
    task automatic cap(input logic e, input logic [2:0] p, input logic s);
        logic [7:0] n;
        logic [7:0] got;
        n = 8'h80 >> (p + 3'h2);
        bus(1'b1, 32'h0, 32'h0);
        bus(1'b1, 32'h4, 32'h0);
        pn(e, 8);
        bus(1'b1, 32'h0, {24'h0, 2'h3, s, 1'h1, e, p});
        pn(e, 20);
        rd(32'h8, 32'h0);
        pn(!e, 8);
        rd(32'h8, 32'h0);
        pn(e, 128);
        pn(!e, 8);
        bus(1'b0, 32'h8, 32'h0);
        got = q[7:0];
        check("width", {31'h0, got + 8'h1 >= n && got <= n + 8'h1}, 32'h1);
        rd(32'h0, {24'h0, 2'h3, s, 1'h0, e, p});
        pn(e, 8);
        pn(!e, 8);
        rd(32'h8, {24'h0, got});
    endtask
    task automatic summarize;
        $display("comparisons %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, sleep_mode, alt_overflow} = '0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // reset values, alias above the map, read-only count
        rd(32'h0, 32'h08);
        rd(32'h4, 32'h00);
        rd(32'hC, 32'hC0);
        rd(32'h1C, 32'hC0);
        bus(1'b1, 32'h8, 32'h55);
        rd(32'h8, 32'h00);
        // event counting on rising edges, then overflow while asleep
        bus(1'b1, 32'h4, 32'hFC);
        rd(32'h8, 32'hFC);
        bus(1'b1, 32'h0, 32'h50);
        pn(1'b1, 8);
        rd(32'h8, 32'hFD);
        pn(1'b0, 8);
        rd(32'h8, 32'hFD);
        repeat (2)
        begin
            pn(1'b1, 8);
            pn(1'b0, 8);
        end
        bus(1'b1, 32'h4, 32'hF0);
        rd(32'h8, 32'hFF);
        sleep_mode <= 1'b1;
        pn(1'b1, 8);
        pn(1'b0, 8);
        sleep_mode <= 1'b0;
        rd(32'h8, 32'hF0);
        check("irqs", irqs, 32'h1);
        check("wakes", wakes, 32'h1);
        rd(32'h0, 32'h50);
        // falling edge selected
        bus(1'b1, 32'h0, 32'h58);
        pn(1'b1, 8);
        rd(32'h8, 32'hF0);
        pn(1'b0, 8);
        rd(32'h8, 32'hF1);
        // capture with both edge senses over four prescaler codes, two on the crystal
        for (int c = 0; c < 4; c++)
            cap(c[0], c[2:0], c[1]);
        // divider on own overflow, every rising edge overflows from full count
        bus(1'b1, 32'h0, 32'h0);
        bus(1'b1, 32'h4, 32'hFF);
        bus(1'b1, 32'h0, 32'h50);
        bus(1'b1, 32'hC, 32'h14);
        // let the gate bit reach the registered pins before taking the reference
        repeat (2) @(posedge hclk);
        repeat (3)
        begin
            b = freq_div_out;
            pn(1'b1, 8);
            pn(1'b0, 8);
            check("div", {31'h0, freq_div_out}, {31'h0, !b});
            check("div_n", {31'h0, freq_div_out_n}, {31'h0, !freq_div_out});
        end
        // other counter as source: own overflow no longer toggles
        bus(1'b1, 32'hC, 32'h15);
        b = freq_div_out;
        pn(1'b1, 8);
        pn(1'b0, 8);
        check("div_src", {31'h0, freq_div_out}, {31'h0, b});
        alt_overflow <= 1'b1;
        @(posedge hclk);
        alt_overflow <= 1'b0;
        repeat (4) @(posedge hclk);
        check("div_alt", {31'h0, freq_div_out}, {31'h0, !b});
        // pin enables, directions and the gating bit
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, 32'hC, {24'h0, misc_tab[i] | 8'h01});
            repeat (3) @(posedge hclk);
            check("pins", {28'h0, freq_div_out_oe, freq_div_out_n_oe,
                freq_div_out | freq_div_out_n, freq_div_out_oe & freq_div_out_n_oe},
                {28'h0, out_tab[i][3:2], misc_tab[i][4], out_tab[i][3] & out_tab[i][2]});
        end
        summarize();
    end
endmodule // ecf_timer_tb_top
`default_nettype wire
